/* File: core/hub_interrupt_aggregator.sv */
// Interrupt aggregation for a two-port link receiver hub with one camera output port.
// Assumes the serial target engine turns bus cycles into single-cycle byte
// read and write strobes, and that event inputs are one-cycle pulses.
//
// Functional notes
// R1: Combined interrupt on pin, control 0x23, status 0x24
// R2: Gather both receive ports and transmit port
// R3: Clear latched condition only by source read
// R4: Status bits set regardless of enables; main status port bits 0 and 1 need the per-port enables
// R5: Interrupt routable to any pin via control
// R6: Pin three only open-drain pin
// R7: Output needs source enable and global enable
// R8: Global enable clear: status shown, output idle
// R9: Host writes 0xBF to enable everything
// R10: Host writes 0x81/0x82 per selected port
// R11: Host selects port at 0x4c first
// R12: Per-port enables high 0xD8, low 0xD9
// R13: Per-port read-only flags 0xDA, 0xDB
// R14: Per-port flags mirror port status bits
// R15: Status one, two or camera read clears
// R16: Host enables source, port, then global
// R17: Enabled interrupt drives output low
// R18: Host may read status copies, then clears
// R19: Status bit7 global, 0x10, 0x02, 0x01
// R20: First port status clears on read
// R21: Output released when nothing enabled pending
`timescale 1ns/1ps

module hub_interrupt_aggregator
   import hub_irq_pkg::*;
#(
   parameter int N_RX_PORTS = 2,
   parameter int N_PINS     = 4,
   parameter int OD_PIN     = 3
) (
   input  wire logic                                     ref_clk_i,
   input  wire logic                                     rst_n_i,
   input  wire logic [7:0]                               reg_addr_i,
   input  wire logic [7:0]                               reg_wdata_i,
   input  wire logic                                     reg_wr_i,
   input  wire logic                                     reg_rd_i,
   input  wire logic [N_RX_PORTS-1:0][`EV_WIDTH-1:0]     rx_evt_i,
   input  wire logic [N_RX_PORTS-1:0][`CSI_EV_WIDTH-1:0] csi_rx_evt_i,
   input  wire logic [N_RX_PORTS-1:0]                    rx_lock_i,
   input  wire logic [N_RX_PORTS-1:0]                    rx_pass_i,
   input  wire logic                                     csi_tx_irq_i,
   output logic [7:0]                                    reg_rdata_o,
   output logic                                          irq_out_n_o,
   output logic [N_PINS-1:0]                             pin_out_o,
   output logic [N_PINS-1:0]                             pin_oe_o
);

   // ==========================================
   // Elaboration checks
   if (N_RX_PORTS < 1 || N_RX_PORTS > 2) begin : g_bad_ports
      $error("N_RX_PORTS must be 1 or 2");
   end
   if (OD_PIN < 0 || OD_PIN >= N_PINS || N_PINS > 16) begin : g_bad_pins
      $error("OD_PIN must index one of at most 16 pins");
   end

   // ==========================================
   // State
   typedef struct packed {
      logic [7:0]                                     main_ctl;
      logic [7:0]                                     port_sel;
      logic [N_RX_PORTS-1:0][7:0]                     icr_hi;
      logic [N_RX_PORTS-1:0][7:0]                     icr_lo;
      logic [N_RX_PORTS-1:0][`EV_WIDTH-1:0]           ev;
      logic [N_RX_PORTS-1:0][`CSI_EV_WIDTH-1:0]       csi_ev;
      logic [N_PINS-1:0][`PIN_CTL_WIDTH-1:0]          pin_ctl;
      logic [7:0]                                     rdata;
      logic                                           irq_n;
      logic [N_PINS-1:0]                              pin_out;
      logic [N_PINS-1:0]                              pin_oe;
   } state_t;

   state_t    s_q;
   state_t    s_d;
   reg_kind_t kind;

   // Per-port status copies are views of the latched events, never separate state
   function automatic logic [7:0] isr_lo(input logic [`EV_WIDTH-1:0]     e,
                                         input logic [`CSI_EV_WIDTH-1:0] c);
      return {1'b0, e[`EV_LINE_LEN], e[`EV_LINE_CNT], e[`EV_BUFFER], |c,
              e[`EV_PARITY], e[`EV_PASS_CHG], e[`EV_LOCK_CHG]};          // R14
   endfunction : isr_lo

   function automatic logic [7:0] isr_hi(input logic [`EV_WIDTH-1:0] e);
      return {5'h00, e[`EV_ENC_ERR], e[`EV_BCC_SEQ], e[`EV_BCC_CRC]};      // R14
   endfunction : isr_hi

   assign kind = decode_reg(reg_addr_i, N_PINS);

   // ==========================================
   // Next state
   always_comb begin
      logic [7:0]               sts;
      logic                     rp;
      logic                     irq_lvl;
      logic                     lvl;
      logic [`EV_WIDTH-1:0]     clr;
      logic [`CSI_EV_WIDTH-1:0] cclr;
      logic [7:0]               rd;
      int                       pi;
      s_d     = s_q;
      sts     = 8'h00;
      rp      = 1'b0;
      irq_lvl = 1'b0;
      lvl     = 1'b0;
      clr     = '0;
      cclr    = '0;
      rd      = 8'h00;
      pi      = 0;
      if (N_RX_PORTS > 1) begin
         rp = s_q.port_sel[`BIT_SEL_READ];
      end
      pi = int'(reg_addr_i - `OFS_PIN_CTL_BASE);

      // Status reflects pending conditions that the per-port enables pass, whatever the global enable says
      for (int p = 0; p < N_RX_PORTS; p++) begin
         sts[p] = |(isr_lo(s_q.ev[p], s_q.csi_ev[p]) & s_q.icr_lo[p]) |
                  |(isr_hi(s_q.ev[p]) & s_q.icr_hi[p]);                    // R2 R4
      end
      sts[`BIT_CSI_TX] = csi_tx_irq_i;                                       // R2 R19
      sts[`BIT_INT_EN] = |(sts[4:0] & s_q.main_ctl[4:0] & 5'(`MASK_SRC));   // R7 R8 R19
      irq_lvl = sts[`BIT_INT_EN] & s_q.main_ctl[`BIT_INT_EN];               // R7 R8

      // Read mux; data is captured before the clearing takes effect
      case (kind)
         REG_MAIN_CTL: rd = s_q.main_ctl;
         REG_MAIN_STS: rd = sts;                                             // R19
         REG_PORT_SEL: rd = s_q.port_sel;
         REG_STS_ONE:  rd = {1'b0, rp, s_q.ev[rp][`EV_BCC_CRC], s_q.ev[rp][`EV_LOCK_CHG],
                             s_q.ev[rp][`EV_BCC_SEQ], s_q.ev[rp][`EV_PARITY],
                             rx_pass_i[rp], rx_lock_i[rp]};
         REG_STS_TWO:  rd = {1'b0, s_q.ev[rp][`EV_LINE_LEN], s_q.ev[rp][`EV_ENC_ERR],
                             s_q.ev[rp][`EV_BUFFER], |s_q.csi_ev[rp], 2'b00,
                             s_q.ev[rp][`EV_LINE_CNT]};
         REG_CAM_STS:  rd = {4'h0, s_q.csi_ev[rp]};
         REG_ICR_HI:   rd = s_q.icr_hi[rp];                                  // R12
         REG_ICR_LO:   rd = s_q.icr_lo[rp];                                  // R12
         REG_ISR_HI:   rd = isr_hi(s_q.ev[rp]);                              // R13
         REG_ISR_LO:   rd = isr_lo(s_q.ev[rp], s_q.csi_ev[rp]);              // R13
         REG_PIN_CTL:  rd = {5'h00, s_q.pin_ctl[pi[3:0]]};
         default:      rd = 8'h00;
      endcase
      if (reg_rd_i) begin
         s_d.rdata = rd;
      end

      // Only reads of the source status registers clear, and only the read port
      if (reg_rd_i) begin
         case (kind)
            REG_STS_ONE: clr  = `CLR_STS_ONE;                                // R15 R20
            REG_STS_TWO: clr  = `CLR_STS_TWO;                                // R15
            REG_CAM_STS: cclr = '1;                                          // R15
            default: begin
               clr  = '0;
               cclr = '0;
            end
         endcase
      end
      for (int p = 0; p < N_RX_PORTS; p++) begin
         // A new event in the clearing cycle survives the clear
         if (p == int'(rp)) begin
            s_d.ev[p]     = (s_q.ev[p] & ~clr) | rx_evt_i[p];               // R3
            s_d.csi_ev[p] = (s_q.csi_ev[p] & ~cclr) | csi_rx_evt_i[p];      // R3
         end else begin
            s_d.ev[p]     = s_q.ev[p] | rx_evt_i[p];                         // R4
            s_d.csi_ev[p] = s_q.csi_ev[p] | csi_rx_evt_i[p];                 // R4
         end
      end

      // Writes; per-port registers go to every port enabled for writing
      if (reg_wr_i) begin
         case (kind)
            REG_MAIN_CTL: s_d.main_ctl = reg_wdata_i;                        // R1
            REG_PORT_SEL: s_d.port_sel = reg_wdata_i;
            REG_ICR_HI: begin
               for (int p = 0; p < N_RX_PORTS; p++) begin
                  if (s_q.port_sel[p]) begin
                     s_d.icr_hi[p] = reg_wdata_i;                            // R12
                  end
               end
            end
            REG_ICR_LO: begin
               for (int p = 0; p < N_RX_PORTS; p++) begin
                  if (s_q.port_sel[p]) begin
                     s_d.icr_lo[p] = reg_wdata_i;                            // R12
                  end
               end
            end
            REG_PIN_CTL: s_d.pin_ctl[pi[3:0]] = reg_wdata_i[`PIN_CTL_WIDTH-1:0]; // R5
            default: s_d.main_ctl = s_q.main_ctl;
         endcase
      end

      // Output low while an enabled source is pending, released otherwise
      s_d.irq_n = ~irq_lvl;                                                  // R1 R17 R21

      // Pins: routed interrupt or static level; only pin three is open-drain
      for (int g = 0; g < N_PINS; g++) begin
         lvl = s_q.pin_ctl[g][`PIN_ROUTE_IRQ] ? ~irq_lvl
                                               : s_q.pin_ctl[g][`PIN_OUT_VAL]; // R5
         if (g == OD_PIN) begin
            s_d.pin_out[g] = 1'b0;                                           // R6
            s_d.pin_oe[g]  = s_q.pin_ctl[g][`PIN_OUT_EN] & ~lvl;             // R6
         end else begin
            s_d.pin_out[g] = lvl;
            s_d.pin_oe[g]  = s_q.pin_ctl[g][`PIN_OUT_EN];
         end
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q          <= '0;
         s_q.main_ctl <= `RST_MAIN_CTL;
         s_q.port_sel <= `RST_PORT_SEL;
         s_q.irq_n    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign irq_out_n_o = s_q.irq_n;
   assign pin_out_o   = s_q.pin_out;
   assign pin_oe_o    = s_q.pin_oe;

endmodule : hub_interrupt_aggregator

/* File: core/hub_irq_defs.svh */
// Offsets, field positions and reset values of the hub interrupt aggregator.
// Assumes byte-wide registers at 8-bit offsets on the device register port.
`ifndef HUB_IRQ_DEFS_SVH
`define HUB_IRQ_DEFS_SVH

// ==========================================
// Register offsets
`define OFS_MAIN_CTL      8'h23
`define OFS_MAIN_STS      8'h24
`define OFS_PORT_SEL      8'h4c
`define OFS_LINK_STS_ONE  8'h4d
`define OFS_LINK_STS_TWO  8'h4e
`define OFS_CAM_IN_STS    8'h7a
`define OFS_PIN_CTL_BASE  8'h10
`define OFS_ICR_HI        8'hd8
`define OFS_ICR_LO        8'hd9
`define OFS_ISR_HI        8'hda
`define OFS_ISR_LO        8'hdb

// ==========================================
// Reset values
`define RST_MAIN_CTL      8'h00
`define RST_PORT_SEL      8'h01
`define RST_ICR           8'h00

// ==========================================
// Main control and status fields
`define BIT_INT_EN        7
`define BIT_CSI_TX        4
`define MASK_SRC          8'h1f

// ==========================================
// Port select fields: read port bit, write enables in low bits
`define BIT_SEL_READ      4

// ==========================================
// Per-port event flag positions
`define EV_LOCK_CHG       0
`define EV_PASS_CHG       1
`define EV_PARITY         2
`define EV_BUFFER         3
`define EV_LINE_CNT       4
`define EV_LINE_LEN       5
`define EV_BCC_CRC        6
`define EV_BCC_SEQ        7
`define EV_ENC_ERR        8
`define EV_WIDTH          9
`define CSI_EV_WIDTH      4

// Events cleared by a read of the first and of the second link status
`define CLR_STS_ONE       9'h0c7
`define CLR_STS_TWO       9'h138

// ==========================================
// Pin control fields
`define PIN_OUT_EN        0
`define PIN_OUT_VAL       1
`define PIN_ROUTE_IRQ     2
`define PIN_CTL_WIDTH     3

`endif

/* File: core/hub_irq_pkg.sv */
// Types shared by the hub interrupt aggregator.
// Assumes hub_irq_defs.svh is on the include path.
`include "hub_irq_defs.svh"

package hub_irq_pkg;

   typedef enum {
      REG_NONE,
      REG_MAIN_CTL,
      REG_MAIN_STS,
      REG_PORT_SEL,
      REG_STS_ONE,
      REG_STS_TWO,
      REG_CAM_STS,
      REG_ICR_HI,
      REG_ICR_LO,
      REG_ISR_HI,
      REG_ISR_LO,
      REG_PIN_CTL
   } reg_kind_t;

   // ==========================================
   // Address decode, shared by read and write paths
   function automatic reg_kind_t decode_reg(input logic [7:0] addr,
                                            input int         n_pins);
      reg_kind_t k;
      k = REG_NONE;
      case (addr)
         `OFS_MAIN_CTL:     k = REG_MAIN_CTL;
         `OFS_MAIN_STS:     k = REG_MAIN_STS;
         `OFS_PORT_SEL:     k = REG_PORT_SEL;
         `OFS_LINK_STS_ONE: k = REG_STS_ONE;
         `OFS_LINK_STS_TWO: k = REG_STS_TWO;
         `OFS_CAM_IN_STS:   k = REG_CAM_STS;
         `OFS_ICR_HI:       k = REG_ICR_HI;
         `OFS_ICR_LO:       k = REG_ICR_LO;
         `OFS_ISR_HI:       k = REG_ISR_HI;
         `OFS_ISR_LO:       k = REG_ISR_LO;
         default: begin
            if (addr >= `OFS_PIN_CTL_BASE &&
                32'(addr) < 32'(`OFS_PIN_CTL_BASE) + 32'(n_pins)) begin
               k = REG_PIN_CTL;
            end
         end
      endcase
      return k;
   endfunction : decode_reg

endpackage : hub_irq_pkg

/* File: testbench/hub_irq_checker.sv */
// Assertions on the interrupt aggregator's top-level ports.
// Assumes one clock domain and the register map of hub_irq_defs.svh.
`timescale 1ns/1ps
`include "hub_irq_defs.svh"

module hub_irq_checker #(
   parameter int N_PINS = 4,
   parameter int OD_PIN = 3
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   input  wire logic              csi_tx_irq_i,
   input  wire logic [7:0]        reg_rdata_o,
   input  wire logic              irq_out_n_o,
   input  wire logic [N_PINS-1:0] pin_out_o
);
   // ==========================================
   // Shadow of main control, rebuilt from writes
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   always_comb begin
      ctl_d = ctl_q;
      if (reg_wr_i && reg_addr_i == `OFS_MAIN_CTL) begin
         ctl_d = reg_wdata_i;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_q <= 8'h00;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // ==========================================
   // Properties
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Read and write never share a cycle, so ctl_q is unchanged one cycle on
   chk_ctl_readback: assert property (
      reg_rd_i && reg_addr_i == `OFS_MAIN_CTL |=> reg_rdata_o == ctl_q)
      else $error("main control readback wrong");
   chk_unmapped_zero: assert property (
      reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_sts_tx_bit: assert property (
      reg_rd_i && reg_addr_i == `OFS_MAIN_STS |=> reg_rdata_o[4] == $past(csi_tx_irq_i))
      else $error("status transmit bit wrong");
   chk_sts_global_bit: assert property (
      reg_rd_i && reg_addr_i == `OFS_MAIN_STS |=>
      reg_rdata_o[7] == |(reg_rdata_o[4:0] & ctl_q[4:0]))
      else $error("status global bit wrong");
   chk_gate_global: assert property (
      !ctl_q[7] [*2] |-> irq_out_n_o)
      else $error("interrupt low without global enable");
   chk_low_needs_en: assert property (
      $fell(irq_out_n_o) |-> $past(ctl_q[7]) && $past(|ctl_q[4:0]))
      else $error("interrupt fell without enables");
   chk_no_src_idle: assert property (
      ctl_q[4:0] == 5'h00 [*2] |-> irq_out_n_o)
      else $error("interrupt low with no source enabled");
   chk_tx_drives_low: assert property (
      ctl_q[7] && ctl_q[4] && csi_tx_irq_i [*3] |-> !irq_out_n_o)
      else $error("transmit request did not drive interrupt");
   chk_od_never_high: assert property (
      pin_out_o[OD_PIN] == 1'b0)
      else $error("open drain pin driven high");
endmodule : hub_irq_checker

/* File: testbench/irq_host_model.sv */
// Host side of the interrupt line: pull-up on the open-drain pin.
// Assumes pin drive and enable outputs of the aggregator.
`timescale 1ns/1ps

module irq_host_model #(
   parameter int N_PINS = 4,
   parameter int OD_PIN = 3
) (
   input  wire logic [N_PINS-1:0] pin_out_i,
   input  wire logic [N_PINS-1:0] pin_oe_i,
   output logic                   od_level_o,
   output int                     n_edges_o
);
   // Pull-up wins whenever the pin is released
   assign od_level_o = pin_oe_i[OD_PIN] ? pin_out_i[OD_PIN] : 1'b1;
   initial n_edges_o = 0;
   always @(negedge od_level_o) n_edges_o++;
endmodule : irq_host_model

/* File: testbench/tb_hub_interrupt_aggregator.sv */
// Self-checking bench for the hub interrupt aggregator.
// Assumes the host model on the pins and the checker bound at the foot.
`timescale 1ns/1ps
`include "hub_irq_defs.svh"

module tb_hub_interrupt_aggregator;
   logic                          ref_clk_i    = 1'b0;
   logic                          rst_n_i      = 1'b0;
   logic [7:0]                    reg_addr_i   = 8'h00;
   logic [7:0]                    reg_wdata_i  = 8'h00;
   logic                          reg_wr_i     = 1'b0;
   logic                          reg_rd_i     = 1'b0;
   logic [1:0][`EV_WIDTH-1:0]     rx_evt_i     = '0;
   logic [1:0][`CSI_EV_WIDTH-1:0] csi_rx_evt_i = '0;
   logic [1:0]                    rx_lock_i    = 2'b01;
   logic [1:0]                    rx_pass_i    = 2'b00;
   logic                          csi_tx_irq_i = 1'b0;
   logic [7:0]                    reg_rdata_o;
   logic                          irq_out_n_o;
   logic [3:0]                    pin_out_o;
   logic [3:0]                    pin_oe_o;
   logic                          od_level;
   int                            n_edges;
   int                            n_fail       = 0;
   int                            checks_done  = 0;

   hub_interrupt_aggregator hub_interrupt_aggregator_i (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .rx_evt_i(rx_evt_i),
      .csi_rx_evt_i(csi_rx_evt_i), .rx_lock_i(rx_lock_i), .rx_pass_i(rx_pass_i),
      .csi_tx_irq_i(csi_tx_irq_i), .reg_rdata_o(reg_rdata_o),
      .irq_out_n_o(irq_out_n_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
   irq_host_model irq_host_model_i (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
      .od_level_o(od_level), .n_edges_o(n_edges));

   initial forever #10 ref_clk_i = ~ref_clk_i;

   // ==========================================
   // Bus and compare helpers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // Read data holds until the next read, so a late sample is safe
   task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_i = 1'b0;
      @(negedge ref_clk_i);
      cmp(what, exp, reg_rdata_o);
   endtask : chk_rd
   task automatic chk_irq(input logic exp);
      repeat (3) @(negedge ref_clk_i);
      cmp("irq_out_n", {7'h00, exp}, {7'h00, irq_out_n_o});
   endtask : chk_irq
   task automatic evt(input int p, input int b, input logic cam);
      @(negedge ref_clk_i);
      if (cam) csi_rx_evt_i[p][b] = 1'b1;
      else rx_evt_i[p][b] = 1'b1;
      @(negedge ref_clk_i);
      csi_rx_evt_i = '0;
      rx_evt_i = '0;
   endtask : evt
   task automatic summarize;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize

   // ==========================================
   // Scenarios
   task automatic t_reset;
      logic [7:0] ofs [6] = '{8'h23, 8'h24, 8'h4c, 8'hd8, 8'hd9, 8'h00};
      logic [7:0] exv [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
      foreach (ofs[i]) chk_rd("reset_value", ofs[i], exv[i]);
      chk_irq(1'b1);
   endtask : t_reset
   task automatic t_gate;
      wr(8'h4c, 8'h01);
      wr(8'hd9, 8'h01);
      wr(8'h23, 8'h01);
      evt(0, 0, 1'b0);
      chk_rd("main_status", 8'h24, 8'h81);
      chk_irq(1'b1);
      chk_rd("flags_low", 8'hdb, 8'h01);
      wr(8'hdb, 8'hff);
      chk_rd("flags_low", 8'hdb, 8'h01);
   endtask : t_gate
   task automatic t_port0;
      wr(8'h23, 8'h81);
      chk_irq(1'b0);
      chk_irq(1'b0);
      chk_rd("status_one", 8'h4d, 8'h11);
      chk_irq(1'b1);
      chk_rd("status_one", 8'h4d, 8'h01);
      chk_rd("main_status", 8'h24, 8'h00);
   endtask : t_port0
   task automatic t_port1;
      wr(8'h4c, 8'h12);
      wr(8'hd9, 8'h10);
      wr(8'h23, 8'h82);
      evt(1, 3, 1'b0);
      chk_rd("main_status", 8'h24, 8'h82);
      chk_rd("status_one", 8'h4d, 8'h40);
      chk_irq(1'b0);
      chk_rd("status_two", 8'h4e, 8'h10);
      chk_irq(1'b1);
   endtask : t_port1
   task automatic t_camera;
      wr(8'h4c, 8'h01);
      wr(8'hd9, 8'h08);
      wr(8'h23, 8'hbf);
      evt(0, 2, 1'b1);
      chk_irq(1'b0);
      chk_rd("camera_status", 8'h7a, 8'h04);
      chk_irq(1'b1);
   endtask : t_camera
   task automatic t_route;
      wr(8'h13, 8'h05);
      @(negedge ref_clk_i);
      csi_tx_irq_i = 1'b1;
      chk_irq(1'b0);
      cmp("open_drain_level", 8'h00, {7'h00, od_level});
      chk_rd("main_status", 8'h24, 8'h90);
      @(negedge ref_clk_i);
      csi_tx_irq_i = 1'b0;
      chk_irq(1'b1);
      cmp("open_drain_level", 8'h01, {7'h00, od_level});
      cmp("open_drain_falls", 8'h01, n_edges[7:0]);
   endtask : t_route

   initial begin
      repeat (12) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      t_reset();
      t_gate();
      t_port0();
      t_port1();
      t_camera();
      t_route();
      summarize();
   end

   initial begin
      repeat (3000) @(posedge ref_clk_i);
      n_fail++;
      $display("Error watchdog expected done seen timeout");
      summarize();
   end
endmodule : tb_hub_interrupt_aggregator

bind hub_interrupt_aggregator hub_irq_checker #(.N_PINS(N_PINS), .OD_PIN(OD_PIN))
   hub_irq_checker_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .csi_tx_irq_i(csi_tx_irq_i), .reg_rdata_o(reg_rdata_o),
   .irq_out_n_o(irq_out_n_o), .pin_out_o(pin_out_o));
